// File: design/ddps_pkg.sv
package ddps_pkg;
    // special function register address of the auxiliary control register
    localparam logic [7:0] AUX_CONTROL_ONE_ADDR = 8'ha2;
    // bit positions within the auxiliary control register
    localparam int POINTER_SELECT_BIT = 0;
    localparam int FIXED_ZERO_BIT = 2;
    localparam int USER_FLAG_THREE_BIT = 3;
    localparam int BOOT_ROM_ENABLE_BIT = 5;
    // values after reset
    localparam logic RESET_POINTER_SELECT = 1'b0;
    localparam logic RESET_BOOT_ROM_ENABLE = 1'b0;
    localparam logic RESET_USER_FLAG_THREE = 1'b0;
    localparam logic [15:0] RESET_POINTER = 16'h0000;
    // reserved bits read as this fixed pattern
    localparam logic [7:0] RESERVED_READ = 8'h00;
    // boot rom window
    localparam logic [15:0] BOOT_ROM_BASE = 16'hf800;
    // the switching increment costs this many core clocks
    localparam int INC_SWITCH_CLOCKS = 12;
    localparam int INC_SWITCH_BYTES = 2;
    // pointer operations requested by the core
    typedef enum logic [1:0] {
        DDPS_PTR_NONE,
        DDPS_PTR_LOAD,
        DDPS_PTR_INC
    } ddps_ptr_op_e;
endpackage : ddps_pkg

// File: design/ddps_sfr_port.sv
`timescale 1ns/1ps
`default_nettype none
// sfr-space write/increment decode of the auxiliary control register
module ddps_sfr_port (
    // sfr access from the core
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic i_inc,
    input wire logic [7:0] i_wdata,
    // current register image
    input wire logic [7:0] i_image,
    // decoded update
    output logic o_update,
    output logic [7:0] o_new_value
);
    // register hit; an increment is read-modify-write of the image
    always_comb begin
        o_update = (i_addr == ddps_pkg::AUX_CONTROL_ONE_ADDR) && (i_wr || i_inc);
        if (i_inc) begin
            o_new_value = i_image + 8'h01;
        end else begin
            o_new_value = i_wdata;
        end
    end
endmodule : ddps_sfr_port
`default_nettype wire

// File: design/ddps_top.sv

// block notes
// - two 16-bit pointers, one select bit picks the live one
// - the core sees one control byte at sfr a2
// - control byte layout, msb first:
//     bit 7 reserved, reads 0 here
//     bit 6 reserved, reads 0 here
//     bit 5 boot rom mapping enable
//     bit 4 reserved, reads 0 here
//     bit 3 user flag, no hardware effect
//     bit 2 stuck at zero, never stored
//     bit 1 reserved, reads 0 here
//     bit 0 pointer select
// - increment of the byte is read-modify-write inside the block
// - bit 1 reading zero stops the carry out of bit 0
// - so an increment flips the select and keeps the flag
// - a carry into bit 1 is dropped, bit 1 has no storage
// - software that writes reserved ones gets them dropped
// - reserved bits read zero; callers must not rely on it
// - increment beats write when both strobes arrive together
// - pointer ops use the select as it stood before the edge
// - so a switch and a pointer op in one cycle hit the old pointer
// - the core owns instruction timing; no cycle counter here
// - read data is zero unless the read hit this register
// - read data and hit stand for one cycle only
// - the external pointer output shows the state after the edge
// - the boot enable only leaves the block; decode is elsewhere
// - reset clears select, flag, boot enable and both pointers
// - reset is synchronous, so the clock must run during reset
// - no interrupt, no buffering, no clock enable
// - all state sits in one packed struct, one flop process
// - limitation: pointer op code 3 is ignored, not refused
// - limitation: no read-back path for the pointers over sfr
// - trade-off: registered read data costs a cycle of latency
// - trade-off: gives a clean flop boundary toward the core
`timescale 1ns/1ps
`default_nettype none
module ddps_top (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RESET_N,
    // sfr access from the core
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic I_SFR_WR,
    input wire logic I_SFR_INC,
    input wire logic [7:0] I_SFR_WDATA,
    input wire logic I_SFR_RD,
    output logic [7:0] O_SFR_RDATA,
    output logic O_SFR_HIT,
    // pointer operations from the core
    input wire logic [1:0] I_PTR_OP,
    input wire logic [15:0] I_PTR_WDATA,
    // pointer state
    output logic [15:0] O_EXTERNAL_POINTER,
    output logic [15:0] O_POINTER_ZERO,
    output logic [15:0] O_POINTER_ONE,
    output logic O_POINTER_SELECT,
    output logic O_BOOT_ROM_ENABLE
);
    typedef struct packed {
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic sel;
        logic boot;
        logic flag3;
        logic [7:0] rdata;
        logic hit;
        logic [15:0] ext;
    } ddps_state_s;

    ddps_state_s st_q;
    ddps_state_s st_d;
    logic [7:0] image;
    logic upd;
    logic [7:0] newv;
    ddps_pkg::ddps_ptr_op_e op;

    // register image; reserved bits and bit 2 read as zero
    function automatic logic [7:0] ddps_image(input logic sel, input logic boot, input logic flag3);
        logic [7:0] v;
        v = ddps_pkg::RESERVED_READ;
        v[ddps_pkg::POINTER_SELECT_BIT] = sel;
        v[ddps_pkg::FIXED_ZERO_BIT] = 1'b0;
        v[ddps_pkg::USER_FLAG_THREE_BIT] = flag3;
        v[ddps_pkg::BOOT_ROM_ENABLE_BIT] = boot;
        return v;
    endfunction : ddps_image

    // next value of one pointer for the requested op
    // shared by both pointers so their behaviour cannot drift apart
    function automatic logic [15:0] ddps_ptr_next(
        input ddps_pkg::ddps_ptr_op_e op_in,
        input logic [15:0] cur,
        input logic [15:0] wdata
    );
        logic [15:0] nxt;
        nxt = cur;
        unique case (op_in)
            ddps_pkg::DDPS_PTR_LOAD: begin
                // load takes the full word
                nxt = wdata;
            end
            ddps_pkg::DDPS_PTR_INC: begin
                // wraps at the top of external space
                nxt = cur + 16'h0001;
            end
            default: begin
                // none, or the unused code 3: hold
                nxt = cur;
            end
        endcase
        return nxt;
    endfunction : ddps_ptr_next

    // current read image of the control byte
    assign image = ddps_image(st_q.sel, st_q.boot, st_q.flag3);
    // raw op code from the core, code 3 falls to default
    assign op = ddps_pkg::ddps_ptr_op_e'(I_PTR_OP);

    // decode write and increment; the core sequences the 12-clock instruction
    ddps_sfr_port u_port (
        .i_addr(I_SFR_ADDR),
        .i_wr(I_SFR_WR),
        .i_inc(I_SFR_INC),
        .i_wdata(I_SFR_WDATA),
        .i_image(image),
        .o_update(upd),
        .o_new_value(newv)
    );

    // next state
    always_comb begin
        st_d = st_q;
        if (upd) begin
            // carry from bit 0 dies at reserved bit 1, which reads zero, so the flag survives
            st_d.sel = newv[ddps_pkg::POINTER_SELECT_BIT];
            st_d.flag3 = newv[ddps_pkg::USER_FLAG_THREE_BIT];
            st_d.boot = newv[ddps_pkg::BOOT_ROM_ENABLE_BIT];
        end
        // only the selected pointer moves; the other holds
        // old select used, so a same-cycle switch does not race the op
        if (st_q.sel) begin
            st_d.ptr1 = ddps_ptr_next(op, st_q.ptr1, I_PTR_WDATA);
        end else begin
            st_d.ptr0 = ddps_ptr_next(op, st_q.ptr0, I_PTR_WDATA);
        end
        // read strobe only counts on this register's address
        st_d.hit = I_SFR_RD && (I_SFR_ADDR == ddps_pkg::AUX_CONTROL_ONE_ADDR);
        st_d.rdata = st_d.hit ? image : 8'h00;
        // registered copy of the next active pointer, in step with the pointer registers
        st_d.ext = st_d.sel ? st_d.ptr1 : st_d.ptr0;
    end

    // state register, synchronous reset
    // pointer, select, flag and boot reset values come from the package; read data and hit reset to literal zero
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            st_q.ptr0 <= ddps_pkg::RESET_POINTER;
            st_q.ptr1 <= ddps_pkg::RESET_POINTER;
            st_q.sel <= ddps_pkg::RESET_POINTER_SELECT;
            st_q.boot <= ddps_pkg::RESET_BOOT_ROM_ENABLE;
            st_q.flag3 <= ddps_pkg::RESET_USER_FLAG_THREE;
            st_q.rdata <= 8'h00;
            st_q.hit <= 1'b0;
            st_q.ext <= ddps_pkg::RESET_POINTER;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    // no logic after the flops, keeps core timing simple
    assign O_SFR_RDATA = st_q.rdata;
    assign O_SFR_HIT = st_q.hit;
    assign O_EXTERNAL_POINTER = st_q.ext;
    assign O_POINTER_ZERO = st_q.ptr0;
    assign O_POINTER_ONE = st_q.ptr1;
    assign O_POINTER_SELECT = st_q.sel;
    assign O_BOOT_ROM_ENABLE = st_q.boot;
endmodule : ddps_top
`default_nettype wire

// File: dv/ddps_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ddps_checker (
    // top ports, all watched
    input wire logic I_CORE_CLK, I_RESET_N, I_SFR_WR, I_SFR_INC, I_SFR_RD, O_SFR_HIT, O_POINTER_SELECT,
    input wire logic [7:0] I_SFR_ADDR, I_SFR_WDATA, O_SFR_RDATA,
    input wire logic [1:0] I_PTR_OP,
    input wire logic [15:0] I_PTR_WDATA, O_POINTER_ZERO, O_POINTER_ONE, O_EXTERNAL_POINTER,
    input wire logic O_BOOT_ROM_ENABLE
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESET_N);
    // address decode shared by the sfr checks
    wire logic a = I_SFR_ADDR == ddps_pkg::AUX_CONTROL_ONE_ADDR;
    AST_INC_TOGGLE: assert property (a && I_SFR_INC |=> O_POINTER_SELECT != $past(O_POINTER_SELECT))
        else $error("select not toggled");
    AST_WR_BITS: assert property (a && I_SFR_WR && !I_SFR_INC |=>
        {O_BOOT_ROM_ENABLE, O_POINTER_SELECT} == {$past(I_SFR_WDATA[5]), $past(I_SFR_WDATA[0])}) else $error("bad write");
    AST_READ_HIT: assert property (a && I_SFR_RD |=> O_SFR_HIT && !O_SFR_RDATA[2]) else $error("bad read");
    AST_NO_HIT: assert property (!(a && I_SFR_RD) |=> !O_SFR_HIT) else $error("stray hit");
    AST_EXT_SEL: assert property (O_EXTERNAL_POINTER == (O_POINTER_SELECT ? O_POINTER_ONE : O_POINTER_ZERO))
        else $error("wrong pointer out");
    AST_LOAD_ZERO: assert property (I_PTR_OP == 2'h1 && !O_POINTER_SELECT |=>
        O_POINTER_ZERO == $past(I_PTR_WDATA) && $stable(O_POINTER_ONE)) else $error("bad load");
    AST_INC_ONE: assert property (I_PTR_OP == 2'h2 && O_POINTER_SELECT |=>
        O_POINTER_ONE == $past(O_POINTER_ONE) + 16'h0001 && $stable(O_POINTER_ZERO)) else $error("bad inc");
    AST_IDLE_KEEP: assert property (I_PTR_OP[0] == I_PTR_OP[1] |=> $stable(O_POINTER_ZERO))
        else $error("pointer moved");
    AST_RESET_SEL: assert property ($rose(I_RESET_N) |-> !O_POINTER_SELECT) else $error("select after reset");
endmodule : ddps_checker
bind ddps_top ddps_checker u_chk (.*);
`default_nettype wire

// File: dv/ddps_xmem_model.sv
`timescale 1ns/1ps
`default_nettype none
// external memory side: flags accesses landing in the boot rom window
module ddps_xmem_model (
    input wire logic [15:0] i_addr,
    input wire logic i_boot,
    output logic o_boot_hit
);
    // rom answers only while mapped, plain memory otherwise
    assign o_boot_hit = i_boot && (i_addr >= ddps_pkg::BOOT_ROM_BASE);
endmodule : ddps_xmem_model
`default_nettype wire

// File: dv/dual_data_pointer_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dual_data_pointer_select_tb;
    logic I_CORE_CLK = 1'b0, I_RESET_N = 1'b0, I_SFR_WR = 1'b0, I_SFR_INC = 1'b0, I_SFR_RD = 1'b0;
    logic [7:0] I_SFR_ADDR = 8'h00, I_SFR_WDATA = 8'h00, O_SFR_RDATA, rd_m;
    logic [1:0] I_PTR_OP = 2'h0;
    logic [15:0] I_PTR_WDATA = 16'h0000, O_EXTERNAL_POINTER, O_POINTER_ZERO, O_POINTER_ONE;
    logic O_SFR_HIT, O_POINTER_SELECT, O_BOOT_ROM_ENABLE, boot_hit, s_m, b_m, f_m, hit_m, a;
    logic [31:0] r = 32'hd646;
    logic [15:0] p_m [2];
    int mismatches = 0, tests_run = 0;
    ddps_top dut (.*);
    ddps_xmem_model u_xmem (.i_addr(O_EXTERNAL_POINTER), .i_boot(O_BOOT_ROM_ENABLE), .o_boot_hit(boot_hit));
    always #5 I_CORE_CLK = ~I_CORE_CLK;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        if (mismatches == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    // reference step on the inputs the next edge will take
    task automatic step();
        a = I_SFR_ADDR == ddps_pkg::AUX_CONTROL_ONE_ADDR;
        hit_m = I_RESET_N && a && I_SFR_RD;
        rd_m = hit_m ? {2'b00, b_m, 1'b0, f_m, 2'b00, s_m} : 8'h00;
        if (I_PTR_OP == ddps_pkg::DDPS_PTR_LOAD) p_m[s_m] = I_PTR_WDATA;
        if (I_PTR_OP == ddps_pkg::DDPS_PTR_INC) p_m[s_m] = p_m[s_m] + 16'h0001;
        if (a && I_SFR_INC) s_m = ~s_m;
        else if (a && I_SFR_WR) {b_m, f_m, s_m} = {I_SFR_WDATA[5], I_SFR_WDATA[3], I_SFR_WDATA[0]};
        if (!I_RESET_N) {s_m, f_m, b_m, p_m[0], p_m[1]} = '0;
    endtask : step
    // random traffic, back to back, rare resets in mid-run
    initial begin
        {s_m, f_m, b_m, p_m[0], p_m[1]} = '0;
        repeat (5) @(posedge I_CORE_CLK);
        I_RESET_N <= 1'b1;
        // first 16 cycles: back-to-back switching increments, block-move style
        for (int n = 0; n < 3000; n++) begin
            @(negedge I_CORE_CLK);
            check({O_SFR_HIT, O_SFR_RDATA, O_POINTER_SELECT, O_BOOT_ROM_ENABLE, boot_hit},
                {hit_m, rd_m, s_m, b_m, b_m && p_m[s_m] >= ddps_pkg::BOOT_ROM_BASE});
            check({O_POINTER_ZERO, O_POINTER_ONE, O_EXTERNAL_POINTER}, {p_m[0], p_m[1], p_m[s_m]});
            step();
            @(posedge I_CORE_CLK);
            r = lfsr(lfsr(r));
            I_RESET_N <= (n < 16) || (r[9:4] != 6'h00);
            I_SFR_ADDR <= (n < 16 || r[0]) ? ddps_pkg::AUX_CONTROL_ONE_ADDR : r[15:8];
            I_SFR_RD <= (n >= 16) & r[1] & r[2];
            I_SFR_WR <= !(r[1] & r[2]) & r[3];
            I_SFR_INC <= (n < 16) | (!(r[1] & r[2]) & r[10]);
            I_SFR_WDATA <= r[23:16] & 8'h2d;
            I_PTR_OP <= r[12:11];
            I_PTR_WDATA <= r[31:16];
        end
        summarize();
    end
    // hang guard, well past the planned run
    initial begin
        repeat (4000) @(posedge I_CORE_CLK);
        mismatches++;
        summarize();
    end
endmodule : dual_data_pointer_select_tb
`default_nettype wire
